// [hw/ptu_top.v]
/*
  Six-channel 16-bit pulse timer unit with counter control, general registers and pin logic.
  Assumes a classic Wishbone master on the system clock and asynchronous external pins.
*/
`timescale 1ns/1ns
`include "ptu_defines.vh"
module ptu_top (
  input  wire        SYS_CLK_I,
  input  wire        RST_N_I,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire        EXT_CLK_IN_A_I,
  input  wire        EXT_CLK_IN_B_I,
  input  wire        EXT_CLK_IN_C_I,
  input  wire        EXT_CLK_IN_D_I,
  input  wire [15:0] CC_PIN_I,
  output wire [15:0] CC_PIN_O,
  output wire [15:0] CC_PIN_OE_O
);
  reg  [7:0]  counter_control [0:5];
  reg  [15:0] channel_counter [0:5];
  reg  [15:0] general_reg [0:15];
  reg  [5:0]  phase_en;
  reg  [15:0] pin_out_mode;
  reg  [15:0] pin_lvl;
  reg  [5:0]  run_ctl;
  reg  [5:0]  sync_ctl;
  reg  [5:0]  presc;
  reg  [5:0]  presc_d;
  reg  [5:0]  tick;
  reg  [5:0]  down;
  reg  [6:0]  ovf_chain;
  reg  [17:0] ev;
  reg  [5:0]  clr_own;
  reg  [5:0]  clr;
  reg  [31:0] rd_data;
  reg         any_sync;
  reg  [2:0]  src;
  reg  [1:0]  eg;
  reg  [3:0]  b;
  reg         qa;
  reg         qb;
  reg         ra;
  reg         fa;
  reg         rb;
  reg         fb;
  reg         up_q;
  reg         dn_q;
  wire [3:0]  ext_lvl;
  wire [3:0]  ext_rise;
  wire [3:0]  ext_fall;
  wire [15:0] pin_lvl_in;
  wire [15:0] pin_rise;
  wire [15:0] pin_fall_unused;
  wire [5:0]  p_rise;
  wire [5:0]  p_fall;
  wire        req;
  wire [2:0]  a_ch;
  wire [2:0]  a_slot;
  wire [1:0]  a_k;
  wire [3:0]  a_pin;
  wire        a_gr_ok;

  // First register index and pin of each channel; the pin vector follows the same order.
  function [3:0] pin_base;
    input integer ch;
    begin
      case (ch)
        0:       pin_base = 4'h0;
        1:       pin_base = 4'h4;
        2:       pin_base = 4'h6;
        3:       pin_base = 4'h8;
        4:       pin_base = 4'hC;
        default: pin_base = 4'hE;
      endcase
    end
  endfunction

  function has_cd;
    input integer ch;
    begin
      has_cd = (ch == 0) || (ch == 3);
    end
  endfunction

  function phase_ch;
    input integer ch;
    begin
      phase_ch = !has_cd(ch);
    end
  endfunction

  function edge_pick;
    input       rise;
    input       fall;
    input [1:0] sel;
    begin
      if (sel[`PTU_CKEG_BOTH])
        edge_pick = rise | fall;
      else if (sel[`PTU_CKEG_FALL])
        edge_pick = fall;
      else
        edge_pick = rise;
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] data;
    input [1:0]  sel;
    begin
      merge16 = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  ptu_pin_sync #(
    .W(4)
  ) u_ext_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .pin_i   ({EXT_CLK_IN_D_I, EXT_CLK_IN_C_I, EXT_CLK_IN_B_I, EXT_CLK_IN_A_I}),
    .level_o (ext_lvl),
    .rise_o  (ext_rise),
    .fall_o  (ext_fall)
  );

  ptu_pin_sync #(
    .W(16)
  ) u_pin_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .pin_i   (CC_PIN_I),
    .level_o (pin_lvl_in),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall_unused)
  );

  // A pin in output mode drives its compare level; otherwise it is a capture input.
  assign CC_PIN_O    = pin_lvl;
  assign CC_PIN_OE_O = pin_out_mode;

  assign p_rise  = presc & ~presc_d;
  assign p_fall  = ~presc & presc_d;
  assign req     = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign a_ch    = WB_ADR_I[`PTU_ADR_CH];
  assign a_slot  = WB_ADR_I[`PTU_ADR_SLOT];
  assign a_k     = a_slot[1:0];
  assign a_pin   = pin_base(a_ch) + {2'b00, a_k};
  assign a_gr_ok = (a_ch < `PTU_NCH) && a_slot[2] && (has_cd(a_ch) || !a_k[1]);

  // Count enables, compare/capture events and clearing, worked out channel by channel.
  always @* begin : chan_logic
    integer c;
    integer k;
    c            = 0;
    k            = 0;
    tick         = 6'h00;
    down         = 6'h00;
    ovf_chain    = 7'h00;
    ev           = 18'h00000;
    clr_own      = 6'h00;
    clr          = 6'h00;
    any_sync     = 1'b0;
    src          = 3'h0;
    eg           = 2'h0;
    b            = 4'h0;
    qa           = 1'b0;
    qb           = 1'b0;
    ra           = 1'b0;
    fa           = 1'b0;
    rb           = 1'b0;
    fb           = 1'b0;
    up_q         = 1'b0;
    dn_q         = 1'b0;
    for (c = 0; c < `PTU_NCH; c = c + 1) begin
      src = counter_control[c][`PTU_TPSC];
      eg  = counter_control[c][`PTU_CKEG];
      b   = pin_base(c);
      case (src)
        `PTU_PSC_DIV1:  tick[c] = 1'b1;
        `PTU_PSC_DIV4:  tick[c] = edge_pick(p_rise[`PTU_DIV4_BIT], p_fall[`PTU_DIV4_BIT], eg);
        `PTU_PSC_DIV16: tick[c] = edge_pick(p_rise[`PTU_DIV16_BIT], p_fall[`PTU_DIV16_BIT], eg);
        `PTU_PSC_DIV64: tick[c] = edge_pick(p_rise[`PTU_DIV64_BIT], p_fall[`PTU_DIV64_BIT], eg);
        `PTU_PSC_EXTA:  tick[c] = edge_pick(ext_rise[`PTU_EXT_A], ext_fall[`PTU_EXT_A], eg);
        `PTU_PSC_EXTB:  tick[c] = edge_pick(ext_rise[`PTU_EXT_B], ext_fall[`PTU_EXT_B], eg);
        `PTU_PSC_EXTC:  tick[c] = edge_pick(ext_rise[`PTU_EXT_C], ext_fall[`PTU_EXT_C], eg);
        default: begin
          if (phase_ch(c))
            tick[c] = ovf_chain[c];
          else
            tick[c] = edge_pick(ext_rise[`PTU_EXT_D], ext_fall[`PTU_EXT_D], eg);
        end
      endcase
      if (phase_ch(c) && phase_en[c]) begin
        // Channels 1 and 5 take the A/B pair, channels 2 and 4 the C/D pair.
        if (c == 1 || c == 5) begin
          qa = ext_lvl[`PTU_EXT_A];
          qb = ext_lvl[`PTU_EXT_B];
          ra = ext_rise[`PTU_EXT_A];
          fa = ext_fall[`PTU_EXT_A];
          rb = ext_rise[`PTU_EXT_B];
          fb = ext_fall[`PTU_EXT_B];
        end else begin
          qa = ext_lvl[`PTU_EXT_C];
          qb = ext_lvl[`PTU_EXT_D];
          ra = ext_rise[`PTU_EXT_C];
          fa = ext_fall[`PTU_EXT_C];
          rb = ext_rise[`PTU_EXT_D];
          fb = ext_fall[`PTU_EXT_D];
        end
        up_q    = (ra & ~qb) | (fa & qb) | (rb & qa) | (fb & ~qa);
        dn_q    = (ra & qb) | (fa & ~qb) | (rb & ~qa) | (fb & qa);
        tick[c] = up_q | dn_q;
        down[c] = dn_q;
      end
      tick[c] = tick[c] & run_ctl[c];
      for (k = 0; k < 4; k = k + 1) begin
        if (k < 2 || has_cd(c)) begin
          if (pin_out_mode[b + k])
            ev[b + k] = tick[c] && (channel_counter[c] == general_reg[b + k]);
          else
            ev[b + k] = run_ctl[c] & pin_rise[b + k];
        end
      end
      case (counter_control[c][`PTU_CCLR])
        `PTU_CLR_A: clr_own[c] = ev[b];
        `PTU_CLR_B: clr_own[c] = ev[b + 1];
        `PTU_CLR_C: clr_own[c] = has_cd(c) & ev[b + 2];
        `PTU_CLR_D: clr_own[c] = has_cd(c) & ev[b + 3];
        default:    clr_own[c] = 1'b0;
      endcase
      ovf_chain[c + 1] = tick[c] && !down[c] && (channel_counter[c] == `PTU_CNT_MAX);
    end
    any_sync = |(clr_own & sync_ctl);
    for (c = 0; c < `PTU_NCH; c = c + 1) begin
      clr[c] = clr_own[c] | (sync_ctl[c] & any_sync &
               (counter_control[c][`PTU_CCLR_LOW] == `PTU_CLR_SYNC));
    end
  end

  // Read multiplexer; unmapped addresses answer with zero.
  always @* begin
    rd_data = 32'h00000000;
    if (a_ch == `PTU_COMMON_CH) begin
      if (a_slot == `PTU_CMN_RUN)
        rd_data = {26'h0000000, run_ctl};
      else if (a_slot == `PTU_CMN_SYNC)
        rd_data = {26'h0000000, sync_ctl};
    end else if (a_ch < `PTU_NCH) begin
      case (a_slot)
        `PTU_SLOT_CTRL:  rd_data = {24'h000000, counter_control[a_ch]};
        `PTU_SLOT_MODE:  rd_data = {31'h00000000, phase_en[a_ch]};
        `PTU_SLOT_PINFN: begin
          rd_data[0] = pin_out_mode[pin_base(a_ch)];
          rd_data[1] = pin_out_mode[pin_base(a_ch) + 4'h1];
          rd_data[2] = has_cd(a_ch) & pin_out_mode[pin_base(a_ch) + 4'h2];
          rd_data[3] = has_cd(a_ch) & pin_out_mode[pin_base(a_ch) + 4'h3];
        end
        `PTU_SLOT_CNT:   rd_data = {16'h0000, channel_counter[a_ch]};
        default: begin
          if (a_gr_ok)
            rd_data = {16'h0000, general_reg[a_pin]};
        end
      endcase
    end
  end

  always @(posedge SYS_CLK_I) begin : reg_update
    integer c;
    integer k;
    if (!RST_N_I) begin
      WB_ACK_O     <= 1'b0;
      WB_DAT_O     <= 32'h00000000;
      presc        <= 6'h00;
      presc_d      <= 6'h00;
      phase_en     <= 6'h00;
      run_ctl      <= 6'h00;
      sync_ctl     <= 6'h00;
      pin_out_mode <= 16'h0000;
      pin_lvl      <= 16'h0000;
      for (c = 0; c < `PTU_NCH; c = c + 1) begin
        counter_control[c] <= `PTU_CTRL_RST;
        channel_counter[c] <= `PTU_CNT_RST;
      end
      for (k = 0; k < `PTU_NPIN; k = k + 1)
        general_reg[k] <= `PTU_GR_RST;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= req ? rd_data : 32'h00000000;
      presc    <= presc + 6'h01;
      presc_d  <= presc;
      for (c = 0; c < `PTU_NCH; c = c + 1) begin
        // A bus write to the counter wins over counting; stop the channel first.
        if (req && WB_WE_I && a_ch == c && a_slot == `PTU_SLOT_CNT)
          channel_counter[c] <= merge16(channel_counter[c], WB_DAT_I[15:0], WB_SEL_I[1:0]);
        else if (clr[c])
          channel_counter[c] <= `PTU_CNT_RST;
        else if (tick[c] && down[c])
          channel_counter[c] <= channel_counter[c] - `PTU_ONE16;
        else if (tick[c])
          channel_counter[c] <= channel_counter[c] + `PTU_ONE16;
        for (k = 0; k < 4; k = k + 1) begin
          if (k < 2 || has_cd(c)) begin
            if (req && WB_WE_I && a_gr_ok && a_pin == pin_base(c) + k)
              general_reg[pin_base(c) + k] <= merge16(general_reg[pin_base(c) + k],
                                                      WB_DAT_I[15:0], WB_SEL_I[1:0]);
            else if (ev[pin_base(c) + k] && !pin_out_mode[pin_base(c) + k])
              general_reg[pin_base(c) + k] <= channel_counter[c];
            if (ev[pin_base(c) + k] && pin_out_mode[pin_base(c) + k])
              pin_lvl[pin_base(c) + k] <= ~pin_lvl[pin_base(c) + k];
          end
        end
      end
      if (req && WB_WE_I && WB_SEL_I[0]) begin
        if (a_ch == `PTU_COMMON_CH) begin
          if (a_slot == `PTU_CMN_RUN)
            run_ctl <= WB_DAT_I[5:0];
          else if (a_slot == `PTU_CMN_SYNC)
            sync_ctl <= WB_DAT_I[5:0];
        end else if (a_ch < `PTU_NCH) begin
          case (a_slot)
            `PTU_SLOT_CTRL: begin
              // The control value is meant to change only while the counter is stopped.
              counter_control[a_ch] <= WB_DAT_I[7:0] &
                (has_cd(a_ch) ? `PTU_CTRL_ALL : `PTU_CTRL_NOCD);
            end
            `PTU_SLOT_MODE: phase_en[a_ch] <= WB_DAT_I[0] & phase_ch(a_ch);
            `PTU_SLOT_PINFN: begin
              pin_out_mode[pin_base(a_ch)]        <= WB_DAT_I[0];
              pin_out_mode[pin_base(a_ch) + 4'h1] <= WB_DAT_I[1];
              if (has_cd(a_ch)) begin
                pin_out_mode[pin_base(a_ch) + 4'h2] <= WB_DAT_I[2];
                pin_out_mode[pin_base(a_ch) + 4'h3] <= WB_DAT_I[3];
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end
endmodule // ptu_top

// [pkg/ptu_defines.vh]
/*
  Constants of the pulse timer unit: register slots, field positions, codes and reset values.
  Assumes it is included by bare name by the timer design files only.
*/
`ifndef PTU_DEFINES_VH
`define PTU_DEFINES_VH
`define PTU_NCH         6
`define PTU_NPIN        16
`define PTU_ADR_CH      7:5
`define PTU_ADR_SLOT    4:2
`define PTU_SLOT_CTRL   3'h0
`define PTU_SLOT_MODE   3'h1
`define PTU_SLOT_PINFN  3'h2
`define PTU_SLOT_CNT    3'h3
`define PTU_SLOT_GR0    3'h4
`define PTU_COMMON_CH   3'h6
`define PTU_CMN_RUN     3'h0
`define PTU_CMN_SYNC    3'h1
`define PTU_CCLR        7:5
`define PTU_CCLR_TOP    7
`define PTU_CCLR_LOW    6:5
`define PTU_CKEG        4:3
`define PTU_CKEG_BOTH   1
`define PTU_CKEG_FALL   0
`define PTU_TPSC        2:0
`define PTU_CLR_A       3'h1
`define PTU_CLR_B       3'h2
`define PTU_CLR_C       3'h5
`define PTU_CLR_D       3'h6
`define PTU_CLR_SYNC    2'h3
`define PTU_PSC_DIV1    3'h0
`define PTU_PSC_DIV4    3'h1
`define PTU_PSC_DIV16   3'h2
`define PTU_PSC_DIV64   3'h3
`define PTU_PSC_EXTA    3'h4
`define PTU_PSC_EXTB    3'h5
`define PTU_PSC_EXTC    3'h6
`define PTU_PSC_LAST    3'h7
`define PTU_DIV4_BIT    1
`define PTU_DIV16_BIT   3
`define PTU_DIV64_BIT   5
`define PTU_EXT_A       0
`define PTU_EXT_B       1
`define PTU_EXT_C       2
`define PTU_EXT_D       3
`define PTU_CTRL_RST    8'h00
`define PTU_CTRL_NOCD   8'h7F
`define PTU_CTRL_ALL    8'hFF
`define PTU_CNT_RST     16'h0000
`define PTU_CNT_MAX     16'hFFFF
`define PTU_GR_RST      16'hFFFF
`define PTU_ONE16       16'h0001
`endif

// [hw/ptu_pin_sync.v]
/*
  Input conditioner for asynchronous pins: three flip-flop chain, accepted level and edge pulses.
  Assumes a single system clock; pins may change at any time.
*/
`timescale 1ns/1ns
module ptu_pin_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] pin_i,
  output reg  [W-1:0] level_o,
  output reg  [W-1:0] rise_o,
  output reg  [W-1:0] fall_o
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  wire [W-1:0] agree;

  // The first stage feeds only the second; a change is trusted once stages two and three agree.
  assign agree = ~(s2 ^ s3);

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1      <= {W{1'b0}};
      s2      <= {W{1'b0}};
      s3      <= {W{1'b0}};
      level_o <= {W{1'b0}};
      rise_o  <= {W{1'b0}};
      fall_o  <= {W{1'b0}};
    end else begin
      s1      <= pin_i;
      s2      <= s1;
      s3      <= s2;
      level_o <= (agree & s3) | (~agree & level_o);
      rise_o  <= agree & s3 & ~level_o;
      fall_o  <= agree & ~s3 & level_o;
    end
  end
endmodule // ptu_pin_sync

// [tb/ptu_sva.sv]
/*
  Checker for the timer unit: bus handshake, read masks and pin enable changes.
  Assumes it is bound to ptu_top and sees only that module's ports.
*/
`timescale 1ns/1ns
module ptu_sva (
  input wire        SYS_CLK_I,
  input wire        RST_N_I,
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_WE_I,
  input wire [7:0]  WB_ADR_I,
  input wire [3:0]  WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire        WB_ACK_O,
  input wire        EXT_CLK_IN_A_I,
  input wire        EXT_CLK_IN_B_I,
  input wire        EXT_CLK_IN_C_I,
  input wire        EXT_CLK_IN_D_I,
  input wire [15:0] CC_PIN_I,
  input wire [15:0] CC_PIN_O,
  input wire [15:0] CC_PIN_OE_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire rd_ctrl = take && !WB_WE_I && WB_ADR_I[4:0] == 5'h00;
  wire two_reg = WB_ADR_I[7:5] != 3'h0 && WB_ADR_I[7:5] != 3'h3 && WB_ADR_I[7:5] < 3'h6;
  chk_ack_timing: assert property (take |=> WB_ACK_O)
    else $error("ack not one cycle after request");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(take))
    else $error("ack without request");
  chk_data_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  chk_ctrl_width: assert property (rd_ctrl |=> WB_DAT_O[31:8] == 24'h0)
    else $error("control read wider than eight bits");
  chk_bit7_zero: assert property (rd_ctrl && two_reg |=> !WB_DAT_O[7])
    else $error("bit 7 set on two register channel");
  chk_unmapped_zero: assert property (take && !WB_WE_I && WB_ADR_I[7:5] == 3'h7 |=>
    WB_DAT_O == 32'h0) else $error("unmapped read not zero");
  chk_reset_quiet: assert property (@(posedge SYS_CLK_I) disable iff (1'b0)
    !RST_N_I |=> !WB_ACK_O && CC_PIN_OE_O == 16'h0 && CC_PIN_O == 16'h0)
    else $error("outputs active in reset");
  chk_oe_by_bus: assert property (!$stable(CC_PIN_OE_O) |-> WB_ACK_O || $past(WB_ACK_O))
    else $error("pin enable changed without write");
  cover property (rd_ctrl && two_reg);
  cover property (take && WB_WE_I);
  cover property ($rose(CC_PIN_OE_O[0]));
endmodule // ptu_sva
bind ptu_top ptu_sva u_sva (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .EXT_CLK_IN_A_I(EXT_CLK_IN_A_I),
  .EXT_CLK_IN_B_I(EXT_CLK_IN_B_I), .EXT_CLK_IN_C_I(EXT_CLK_IN_C_I),
  .EXT_CLK_IN_D_I(EXT_CLK_IN_D_I), .CC_PIN_I(CC_PIN_I), .CC_PIN_O(CC_PIN_O),
  .CC_PIN_OE_O(CC_PIN_OE_O));

// [tb/ptu_pin_model.sv]
/*
  Far-side model: external clocks, quadrature pairs and capture levels on the pins.
  Assumes the system clock as time base; all changes follow a rising edge.
*/
`timescale 1ns/1ns
module ptu_pin_model (
  input  wire        clk_i,
  input  wire [15:0] oe_i,
  input  wire [15:0] drv_i,
  output reg  [3:0]  ext_o,
  output wire [15:0] pin_o
);
  reg [15:0] src;
  // A driven pin shows the unit's level, a released one what the far side drives.
  assign pin_o = (oe_i & drv_i) | (~oe_i & src);
  initial begin
    ext_o = 4'h0;
    src = 16'h0;
  end
  // Slow pulses keep well clear of the input filter latency.
  task pulse(input integer i, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k++) begin
        repeat (8) @(posedge clk_i);
        ext_o[i] <= 1'b1;
        repeat (8) @(posedge clk_i);
        ext_o[i] <= 1'b0;
      end
    end
  endtask
  // Phase A leads phase B; four edges per full cycle.
  task quad(input integer a, input integer n);
    integer k;
    integer s;
    begin
      for (k = 0; k < n; k++) begin
        for (s = 0; s < 4; s++) begin
          repeat (8) @(posedge clk_i);
          ext_o[a + s % 2] <= (s < 2);
        end
      end
    end
  endtask
  task pin(input integer i, input v);
    begin
      @(posedge clk_i);
      src[i] <= v;
    end
  endtask
endmodule // ptu_pin_model

// [tb/tb_multichannel_timer_pins_and_control.sv]
/*
  Testbench of the timer unit: register access, clock sources, clearing and capture.
  Assumes ptu_top, its checker and the pin model are compiled beforehand.
*/
`timescale 1ns/1ns
module tb_multichannel_timer_pins_and_control;
  reg         clk, rst_n, cyc, stb, we;
  reg  [7:0]  adr;
  reg  [3:0]  sel;
  reg  [31:0] dat_w, q;
  reg  [15:0] c0;
  wire [31:0] dat_r;
  wire        ack;
  wire [3:0]  ext;
  wire [15:0] pin_i, pin_o, pin_oe;
  integer     miscompares, cmp_count, i, n;
  ptu_top DUT (.SYS_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
    .WB_ACK_O(ack), .EXT_CLK_IN_A_I(ext[0]), .EXT_CLK_IN_B_I(ext[1]),
    .EXT_CLK_IN_C_I(ext[2]), .EXT_CLK_IN_D_I(ext[3]), .CC_PIN_I(pin_i),
    .CC_PIN_O(pin_o), .CC_PIN_OE_O(pin_oe));
  ptu_pin_model u_pins (.clk_i(clk), .oe_i(pin_oe), .drv_i(pin_o), .ext_o(ext),
    .pin_o(pin_i));
  always #50 clk = ~clk;
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task check(input ok, input [31:0] got);
    begin
      cmp_count++;
      if (ok !== 1'b1) begin
        miscompares++;
        $display("wrong value at %0t: got %h", $time, got);
      end
    end
  endtask
  // Requests rise after an edge and are held until ack is seen at an edge.
  task xfer(input [7:0] a, input w, input [31:0] d);
    integer t;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      t = 0;
      @(posedge clk);
      while (ack !== 1'b1 && t < 20) begin
        @(posedge clk);
        t++;
      end
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (t >= 20) begin
        miscompares++;
        conclude;
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rd(input [7:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask
  // Control is only rewritten while the channel is stopped.
  task start(input integer ch, input [7:0] ctl);
    begin
      wr(8'(ch * 32 + 12), 32'h0);
      wr(8'(ch * 32), {24'h0, ctl});
      wr(8'hC0, 32'(1 << ch));
    end
  endtask
  task stop(input integer ch);
    begin
      wr(8'hC0, 32'h0);
      rd(8'(ch * 32 + 12));
    end
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat_w = 32'h0;
    miscompares = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      rd(8'(i * 32));
      check(q === 32'h0, q);
      rd(8'(i * 32 + 16));
      check(q === 32'h0000FFFF, q);
      wr(8'(i * 32), 32'hFF);
      rd(8'(i * 32));
      check(q === ((i % 3 == 0) ? 32'hFF : 32'h7F), q);
      wr(8'(i * 32), 32'h0);
    end
    rd(8'hE0);
    check(q === 32'h0, q);
    for (i = 0; i < 3; i++) begin
      start(0, 8'(i * 8));
      repeat (20) @(posedge clk);
      stop(0);
      if (i == 0)
        c0 = q[15:0];
      check(q[15:0] === c0 && q > 19 && q < 26, q);
    end
    // Divide-by-four: one edge gives 5 or 6 counts in the window, both edges 11 or 12.
    for (i = 0; i < 2; i++) begin
      start(0, 8'(1 + i * 16));
      repeat (20) @(posedge clk);
      stop(0);
      check(q >= 5 + i * 6 && q <= 6 + i * 6, q);
    end
    for (i = 0; i < 6; i++) begin
      n = (i < 3) ? 0 : i - 2;
      start(0, 8'(4 + n + ((i < 3) ? i * 8 : 0)));
      u_pins.pulse(n, 5);
      repeat (10) @(posedge clk);
      stop(0);
      check(q === ((i == 2) ? 32'd10 : 32'd5), q);
    end
    for (i = 1; i < 6; i++) begin
      if (i != 3) begin
        wr(8'(i * 32 + 4), 32'h1);
        start(i, 8'h08);
        u_pins.quad((i == 1 || i == 5) ? 0 : 2, 2);
        repeat (10) @(posedge clk);
        stop(i);
        check(q === 32'd8, q);
        wr(8'(i * 32 + 4), 32'h0);
      end
    end
    wr(8'h08, 32'h3);
    wr(8'h10, 32'h9);
    wr(8'h14, 32'h5);
    check(pin_oe[1:0] === 2'b11, pin_oe);
    for (i = 0; i < 3; i++) begin
      start(0, 8'(i * 32));
      repeat (30) @(posedge clk);
      stop(0);
      check((i == 0) ? q > 20 : q <= ((i == 1) ? 9 : 5), q);
      if (i == 0)
        check(pin_o[1:0] === 2'b11, {16'h0, pin_o});
    end
    wr(8'hC4, 32'h9);
    wr(8'h60, 32'h60);
    wr(8'h6C, 32'h0);
    start(0, 8'h20);
    wr(8'hC0, 32'h9);
    repeat (30) @(posedge clk);
    wr(8'hC0, 32'h0);
    rd(8'h6C);
    check(q <= 9, q);
    wr(8'hC4, 32'h0);
    wr(8'h08, 32'h0);
    start(0, 8'h00);
    repeat (10) @(posedge clk);
    u_pins.pin(1, 1'b1);
    repeat (10) @(posedge clk);
    stop(0);
    c0 = q[15:0];
    rd(8'h14);
    check(q > 8 && q < {16'h0, c0}, q);
    // Channel 1 counts channel 0 wrapping once from FFFF; its both-edge setting must not matter.
    wr(8'h2C, 32'h0);
    wr(8'h20, 32'h17);
    wr(8'h0C, 32'hFFFE);
    wr(8'hC0, 32'h3);
    repeat (10) @(posedge clk);
    wr(8'hC0, 32'h0);
    rd(8'h2C);
    check(q === 32'h1, q);
    conclude;
  end
endmodule // tb_multichannel_timer_pins_and_control
